// ===== verilog/slod_cfg.svh
`ifndef SLOD_CFG_SVH
`define SLOD_CFG_SVH

// width of the shift, storage and output-buffer words
`define SLOD_REG_BITS   8
// index of the last shift stage, which feeds the chain output
`define SLOD_LAST_STAGE 7
// depth of the latched-word stream buffer
`define SLOD_FIFO_DEPTH 16
// width of the latched-word stream buffer
`define SLOD_FIFO_WIDTH 8
// value the shift and storage registers take while clear is held
`define SLOD_CLEAR_WORD 8'h00
// drain enables while off: all high, nothing sinks
`define SLOD_DRAIN_OFF  8'hFF

`endif

// ===== verilog/slod_pkg.sv
package slod_pkg;
	`include "slod_cfg.svh"

	// one data word of the register chain
	typedef logic [`SLOD_REG_BITS-1:0] slod_word_t;

	// the five host pins, kept together through every sync stage
	typedef struct packed {
		logic shift_clock;      // rising edge advances the shifter
		logic latch_clock;      // rising edge loads the storage word
		logic serial_input;     // data bit for the first stage
		logic clear_n;          // low clears shifter, storage and drop flag
		logic output_enable_n;  // high forces every drain off
	} slod_pins_t;

	// every flip-flop of the top module
	typedef struct packed {
		slod_pins_t meta;           // first sync stage, read by sync only
		slod_pins_t sync;           // second sync stage
		slod_pins_t last;           // previous sync value, for edge finding
		slod_word_t shifter;        // serial-in parallel-out stages
		slod_word_t storage;        // word loaded on latch edges
		slod_word_t drain_oe_n;     // low while a drain sinks current
		logic       drain_level;    // level driven on enabled drains
		logic       serial_output;  // copy of the last shift stage
		logic       push;           // one-cycle write into the buffer
		slod_word_t push_word;      // word offered to the buffer
		logic       dropped;        // latch seen while the buffer was full
	} slod_state_t;
endpackage : slod_pkg

// ===== verilog/slod_driver.sv
// How it works
// - eight-bit shifter feeding eight-bit storage register
// - shift clock rise shifts, serial bit enters
// - latch clock rise copies shifter into storage
// - clear low zeroes shifter and storage registers
// - storage reaches buffers only while clear high
// - output enable high turns all drains off
// - output enable low passes storage transparently
// - buffer one sinks current, zero is off
// - shifter data leaves on the serial output
// - loaded ones switch on, zeros off, when enabled
`timescale 1ns/1ps
`include "slod_cfg.svh"

// latched-word stream buffer, storage in flip-flops
module slod_fifo #(
	parameter int WIDTH = `SLOD_FIFO_WIDTH,
	parameter int DEPTH = `SLOD_FIFO_DEPTH
) (
	input  wire logic             sys_clk,    // system clock
	input  wire logic             srst,       // synchronous reset, high
	input  wire logic             in_valid,   // writer offers a word
	output logic                  in_ready,   // room for one more word
	input  wire logic [WIDTH-1:0] in_data,    // word to store
	output logic                  out_valid,  // a word is waiting
	input  wire logic             out_ready,  // reader takes the word
	output logic      [WIDTH-1:0] out_data    // oldest word
);
	localparam int AW = $clog2(DEPTH);

	// pointers wrap naturally, so depth must be a power of two
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_size
		$error("slod_fifo: bad width or depth");
	end

	// every flip-flop of the buffer
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;        // storage words
		logic [AW-1:0]               wr_ptr;     // next write slot
		logic [AW-1:0]               rd_ptr;     // oldest slot
		logic [AW:0]                 count;      // words held
		logic                        in_ready;   // not full, registered
		logic                        out_valid;  // not empty, registered
		logic [WIDTH-1:0]            out_data;   // head word, registered
	} slod_fifo_state_t;

	slod_fifo_state_t st;       // all registers
	slod_fifo_state_t next_st;  // their next values
	logic             do_wr;    // write this cycle
	logic             do_rd;    // read this cycle

	assign do_wr     = in_valid && st.in_ready;
	assign do_rd     = st.out_valid && out_ready;
	assign in_ready  = st.in_ready;
	assign out_valid = st.out_valid;
	assign out_data  = st.out_data;

	// pointer and count update; simultaneous read and write keep the count
	always_comb begin
		next_st = st;
		if (do_wr) begin
			next_st.mem[st.wr_ptr] = in_data;
			next_st.wr_ptr         = st.wr_ptr + 1'b1;
		end
		if (do_rd)
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		if (do_wr && !do_rd)
			next_st.count = st.count + 1'b1;
		else if (do_rd && !do_wr)
			next_st.count = st.count - 1'b1;
		// flags and head from the next state, so outputs leave flops directly
		next_st.in_ready  = (next_st.count != (AW+1)'(DEPTH));
		next_st.out_valid = (next_st.count != '0);
		// a word written into the head slot this cycle is seen at once
		next_st.out_data  = next_st.mem[next_st.rd_ptr];
	end

	// buffer registers; empty and ready after reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st          <= '0;
			st.in_ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
endmodule : slod_fifo

// serial-in latched-output low-side driver
module slod_driver
	import slod_pkg::*;
#(
	parameter int FIFO_DEPTH = `SLOD_FIFO_DEPTH
) (
	input  wire logic       sys_clk,          // system clock, 40 MHz
	input  wire logic       srst,             // synchronous reset, high
	input  wire logic       shift_clock,      // host shift clock pin
	input  wire logic       latch_clock,      // host latch clock pin
	input  wire logic       serial_input,     // host serial data pin
	input  wire logic       clear_n,          // host clear pin, low active
	input  wire logic       output_enable_n,  // host output enable, low active
	output logic            serial_output,    // chain output to next device
	output slod_word_t      drain_out,        // drain level, always low
	output slod_word_t      drain_oe_n,       // low while a drain sinks
	output logic            word_valid,       // latched word waiting
	output slod_word_t      word_data,        // oldest latched word
	input  wire logic       word_ready,       // consumer takes the word
	output logic            capture_ready,    // buffer can take a latch
	output logic            capture_dropped   // a latch found the buffer full
);
	// a one-word buffer cannot tell full from empty
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("slod_driver: buffer depth too small");
	end

	slod_state_t st;       // all registers
	slod_state_t next_st;  // their next values
	slod_pins_t  pins;     // raw pin bundle
	logic        sh_rise;  // shift clock edge seen this cycle
	logic        lt_rise;  // latch clock edge seen this cycle
	logic        fifo_in_ready;  // buffer has room

	assign pins    = '{shift_clock, latch_clock, serial_input, clear_n, output_enable_n};
	// edges come from the second stage only, never the first
	assign sh_rise = st.sync.shift_clock && !st.last.shift_clock;
	assign lt_rise = st.sync.latch_clock && !st.last.latch_clock;

	// next-state logic for the whole device
	always_comb begin
		next_st      = st;
		next_st.meta = pins;
		next_st.sync = st.meta;
		next_st.last = st.sync;
		next_st.push = 1'b0;
		if (!st.sync.clear_n) begin
			// clear needs no clock edge and overrides both clocks
			next_st.shifter = `SLOD_CLEAR_WORD;
			next_st.storage = `SLOD_CLEAR_WORD;
			next_st.dropped = 1'b0;
		end else begin
			if (sh_rise) begin
				// one stage per edge, new bit at the bottom
				next_st.shifter = {st.shifter[`SLOD_LAST_STAGE-1:0], st.sync.serial_input};
			end
			if (lt_rise) begin
				// old shifter value: a same-edge shift is not yet visible
				next_st.storage = st.shifter;
				if (fifo_in_ready) begin
					next_st.push      = 1'b1;
					next_st.push_word = st.shifter;
				end else begin
					// buffer full: the storage still loads, only the copy is lost
					next_st.dropped = 1'b1;
				end
			end
		end
		// chain output follows the last stage
		next_st.serial_output = next_st.shifter[`SLOD_LAST_STAGE];
		// gate by clear and enable; a one sinks current
		if (st.sync.clear_n && !st.sync.output_enable_n)
			next_st.drain_oe_n = ~st.storage;
		else
			next_st.drain_oe_n = `SLOD_DRAIN_OFF;
		next_st.drain_level = 1'b0;
	end

	// state register; drains come out of reset switched off
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st            <= '0;
			st.drain_oe_n <= `SLOD_DRAIN_OFF;
		end else begin
			st <= next_st;
		end
	end

	slod_fifo #(
		.WIDTH (`SLOD_REG_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.in_valid  (st.push),
		.in_ready  (fifo_in_ready),
		.in_data   (st.push_word),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

	assign serial_output   = st.serial_output;
	assign drain_out       = {`SLOD_REG_BITS{st.drain_level}};
	assign drain_oe_n      = st.drain_oe_n;
	assign capture_ready   = fifo_in_ready;
	assign capture_dropped = st.dropped;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// a latch edge the buffer accepts
	sequence s_latch_taken;
		lt_rise && st.sync.clear_n && fifo_in_ready;
	endsequence

	// a shift edge outside clear
	sequence s_shift_edge;
		sh_rise && st.sync.clear_n;
	endsequence

	a_shift_advance: assert property (s_shift_edge |=>
		st.shifter == {$past(st.shifter[6:0]), $past(st.sync.serial_input)})
		else $error("shifter did not advance");
	a_shift_hold: assert property (!sh_rise && st.sync.clear_n |=>
		st.shifter == $past(st.shifter))
		else $error("shifter moved without an edge");
	a_latch_load: assert property (lt_rise && st.sync.clear_n |=>
		st.storage == $past(st.shifter))
		else $error("storage missed latch");
	a_clear_zero: assert property (!st.sync.clear_n |=>
		st.shifter == '0 && st.storage == '0)
		else $error("clear left data");
	a_clear_gate: assert property (!st.sync.clear_n |=> drain_oe_n == '1)
		else $error("drain on during clear");
	a_enable_off: assert property (st.sync.output_enable_n |=> drain_oe_n == '1)
		else $error("drain on while disabled");
	a_enable_pass: assert property (st.sync.clear_n && !st.sync.output_enable_n |=>
		drain_oe_n == ~$past(st.storage))
		else $error("drains do not follow storage");
	a_chain_out: assert property (s_shift_edge |=>
		serial_output == $past(st.shifter[6]))
		else $error("chain output wrong stage");
	a_word_queued: assert property (s_latch_taken |-> ##[1:2] word_valid)
		else $error("latched word not queued");
endmodule : slod_driver

// ===== dv/slod_host_model.sv
`timescale 1ns/1ps

// host side of the pins; the link clock stands still between frames
module slod_host_model (
	input  wire logic sys_clk,          // pacing clock only
	output logic      shift_clock,      // shift pin
	output logic      latch_clock,      // latch pin
	output logic      serial_input,     // data pin
	output logic      clear_n,          // clear pin, low active
	output logic      output_enable_n   // enable pin, low active
);
	// power up with clear held and drains gated off
	initial begin
		shift_clock = 1'b0;
		latch_clock = 1'b0;
		serial_input = 1'b0;
		clear_n = 1'b0;
		output_enable_n = 1'b1;
	end

	// half a 200 ns link period, moved just after a clock edge
	task automatic half();
		repeat (4) @(posedge sys_clk);
		#2;
	endtask : half

	// one bit, one pulse; data settles half a period before the rise
	task automatic shift_bit(input logic d);
		serial_input = d;
		half();
		shift_clock = 1'b1;
		half();
		shift_clock = 1'b0;
	endtask : shift_bit

	// whole word first bit at the top; no latch pulse, the caller latches
	task automatic shift_byte(input logic [7:0] data);
		for (int i = 7; i >= 0; i--) shift_bit(data[i]);
	endtask : shift_byte

	// one latch pulse with settle time on each side
	task automatic latch_pulse();
		// frame over, data line released: show the inverse, never a stale bit
		serial_input = ~serial_input;
		half();
		latch_clock = 1'b1;
		half();
		latch_clock = 1'b0;
		half();
	endtask : latch_pulse

	// clear and enable levels; enable may be toggled to dim
	task automatic set_pins(input logic clr_n, input logic oe_n);
		half();
		clear_n = clr_n;
		output_enable_n = oe_n;
		half();
	endtask : set_pins
endmodule : slod_host_model

// ===== dv/testbench.sv
`timescale 1ns/1ps

// pin-level bench: host model drives the pins, bench drives the stream side
module testbench;
	import slod_pkg::*;
	logic       sys_clk = 1'b0;  // 40 MHz
	logic       srst = 1'b1;     // held at start
	logic       word_ready = 1'b0; // stream consumer
	logic       sck, lck, sin, clr_n, oe_n; // host pins
	logic       serial_output;   // chain output
	slod_word_t drain_out, drain_oe_n, word_data; // drains and stream
	logic       word_valid, capture_ready, capture_dropped; // flags
	logic       chain_serial;    // chain output of the second device
	slod_word_t next_oe_n;       // drain enables of the second device
	int         n_errors = 0;    // mismatches
	int         cmp_count = 0;   // comparisons

	always #12.5 sys_clk = ~sys_clk;

	slod_host_model host (.sys_clk(sys_clk), .shift_clock(sck), .latch_clock(lck),
		.serial_input(sin), .clear_n(clr_n), .output_enable_n(oe_n));
	// small buffer so filling it stays cheap
	slod_driver #(.FIFO_DEPTH(4)) DUT (.sys_clk(sys_clk), .srst(srst), .shift_clock(sck),
		.latch_clock(lck), .serial_input(sin), .clear_n(clr_n), .output_enable_n(oe_n),
		.serial_output(serial_output), .drain_out(drain_out), .drain_oe_n(drain_oe_n),
		.word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
		.capture_ready(capture_ready), .capture_dropped(capture_dropped));
	// second device downstream: chain output feeds its input, clocks shared
	slod_driver #(.FIFO_DEPTH(4)) DUT2 (.sys_clk(sys_clk), .srst(srst), .shift_clock(sck),
		.latch_clock(lck), .serial_input(serial_output), .clear_n(clr_n),
		.output_enable_n(oe_n), .serial_output(chain_serial), .drain_out(),
		.drain_oe_n(next_oe_n), .word_valid(), .word_data(), .word_ready(1'b1),
		.capture_ready(), .capture_dropped());

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	// take one stream word, checking it first
	task automatic pop(input logic [7:0] exp);
		check("word_valid", 8'(word_valid), 8'h01);
		check("word_data", word_data, exp);
		word_ready = 1'b1;
		@(posedge sys_clk);
		#2 word_ready = 1'b0;
		// let an edge pass with ready low before the next take
		@(posedge sys_clk);
		#2;
	endtask : pop

	// load a word and see the drains follow it
	task automatic t_load();
		host.shift_byte(8'hA5);
		host.latch_pulse();
		check("drain_oe_n", drain_oe_n, 8'h5A);
		check("drain_out", drain_out, 8'h00);
		pop(8'hA5);
		host.set_pins(1'b1, 1'b1);
		check("drain_oe_n gated", drain_oe_n, 8'hFF);
		host.set_pins(1'b1, 1'b0);
		check("drain_oe_n open", drain_oe_n, 8'h5A);
		$display("test load done");
	endtask : t_load

	// old word leaves on the chain output one bit per shift
	task automatic t_chain();
		logic [7:0] old_word = 8'hA5;  // word already in the shifter
		logic [7:0] new_word = 8'h3C;  // word shifted in behind it
		for (int i = 0; i < 8; i++) begin
			check("serial_output", 8'(serial_output), 8'(old_word[7 - i]));
			host.shift_bit(new_word[7 - i]);
		end
		check("drain_oe_n held", drain_oe_n, 8'h5A);
		host.latch_pulse();
		check("drain_oe_n new", drain_oe_n, 8'hC3);
		pop(8'h3C);
		$display("test chain done");
	endtask : t_chain

	// two chained devices take sixteen bits, then one latch updates both
	task automatic t_cascade();
		host.shift_byte(8'h96);
		host.shift_byte(8'h0F);
		host.latch_pulse();
		check("drain_oe_n near", drain_oe_n, 8'hF0);
		check("drain_oe_n far", next_oe_n, 8'h69);
		check("chain_serial", 8'(chain_serial), 8'h01);
		pop(8'h0F);
		$display("test cascade done");
	endtask : t_cascade

	// clear wins over latching and zeroes both words
	task automatic t_clear();
		host.set_pins(1'b0, 1'b0);
		check("drain_oe_n clear", drain_oe_n, 8'hFF);
		check("serial_output clear", 8'(serial_output), 8'h00);
		host.latch_pulse();
		check("word_valid clear", 8'(word_valid), 8'h00);
		host.set_pins(1'b1, 1'b0);
		check("drain_oe_n storage cleared", drain_oe_n, 8'hFF);
		host.latch_pulse();
		check("drain_oe_n zero", drain_oe_n, 8'hFF);
		pop(8'h00);
		$display("test clear done");
	endtask : t_clear

	// overfill the buffer while stalled, then drain it
	task automatic t_fifo();
		int n = 0;
		host.shift_byte(8'h81);
		repeat (5) host.latch_pulse();
		check("capture_ready", 8'(capture_ready), 8'h00);
		check("capture_dropped", 8'(capture_dropped), 8'h01);
		check("drain_oe_n full", drain_oe_n, 8'h7E);
		for (int i = 0; i < 8 && word_valid === 1'b1; i++) begin
			pop(8'h81);
			n++;
		end
		check("drained words", 8'(n), 8'h04);
		check("word_valid empty", 8'(word_valid), 8'h00);
		host.set_pins(1'b0, 1'b0);
		check("dropped cleared", 8'(capture_dropped), 8'h00);
		$display("test fifo done");
	endtask : t_fifo

	initial begin
		repeat (5) @(posedge sys_clk);
		#2 srst = 1'b0;
		check("drain_oe_n reset", drain_oe_n, 8'hFF);
		check("word_valid reset", 8'(word_valid), 8'h00);
		check("capture_ready reset", 8'(capture_ready), 8'h01);
		host.set_pins(1'b1, 1'b0);
		t_load();
		t_chain();
		t_cascade();
		t_clear();
		t_fifo();
		print_verdict();
	end
endmodule : testbench
